// ==== verilog/eei_ctrl.sv ====
// External edge interrupt front end with noise filter and zero-cross detector
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module eei_ctrl
#(
   parameter int DIV_FAST_P = eei_pkg::DIV_FAST,
   parameter int DIV_SLOW_P = eei_pkg::DIV_SLOW
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext0_pin,
   input  wire logic        ext1_pin,
   input  wire logic        ext2_pin,
   input  wire logic        zero_cross_input_pin,
   output logic             irq_ext0,
   output logic             irq_ext12,
   output logic             timer2_count_en,
   output logic             wake_level
);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [3:0] first_int_ctrl_reg_r;
   logic [3:0] second_int_ctrl_reg_r;
   logic       third_int_ctrl_reg_r;
   logic       lcd_ctrl_reg_b_r;
   logic [1:0] enable_bits_reg_a_r;
   logic       timer2_ctrl_r;
   logic       fifth_timer_ctrl_r;
   logic       global_irq_enable_r;
   logic       ext0_request_flag_r;
   logic       ext12_request_flag_r;
   logic       canceller_flag_r;
   logic       zero_cross_flag_r;
   logic [31:0] prdata_r;

   logic wr_en;
   logic rd_en;
   logic mapped;
   logic skip0;
   logic skip12;
   logic ack0;
   logic ack12;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction : hit

   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= eei_pkg::ADDR_CMD);
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;

   // Command strobes model the CPU's skip and interrupt-entry actions
   assign skip0  = wr_en && hit(paddr, eei_pkg::ADDR_CMD) && pwdata[eei_pkg::CMD_SKIP0];
   assign skip12 = wr_en && hit(paddr, eei_pkg::ADDR_CMD) && pwdata[eei_pkg::CMD_SKIP12];
   assign ack0   = wr_en && hit(paddr, eei_pkg::ADDR_CMD) && pwdata[eei_pkg::CMD_ACK0];
   assign ack12  = wr_en && hit(paddr, eei_pkg::ADDR_CMD) && pwdata[eei_pkg::CMD_ACK12];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_int_ctrl_reg_r  <= eei_pkg::CTRL_RST;
         second_int_ctrl_reg_r <= eei_pkg::CTRL_RST;
         third_int_ctrl_reg_r  <= 1'b0;
         lcd_ctrl_reg_b_r      <= 1'b0;
         enable_bits_reg_a_r   <= 2'b00;
         timer2_ctrl_r         <= 1'b0;
         fifth_timer_ctrl_r    <= 1'b0;
      end
      else if (wr_en)
      begin
         if (hit(paddr, eei_pkg::ADDR_CTRL1))
            first_int_ctrl_reg_r <= pwdata[3:0];
         if (hit(paddr, eei_pkg::ADDR_CTRL2))
            second_int_ctrl_reg_r <= pwdata[3:0];
         if (hit(paddr, eei_pkg::ADDR_CTRL3))
            third_int_ctrl_reg_r <= pwdata[0];
         if (hit(paddr, eei_pkg::ADDR_LCDB))
            lcd_ctrl_reg_b_r <= pwdata[eei_pkg::LCDB_EXT2_EN];
         if (hit(paddr, eei_pkg::ADDR_ENA))
            enable_bits_reg_a_r <= pwdata[1:0];
         if (hit(paddr, eei_pkg::ADDR_TMR2))
            timer2_ctrl_r <= pwdata[eei_pkg::TMR2_ZC_GATE];
         if (hit(paddr, eei_pkg::ADDR_TMR5))
            fifth_timer_ctrl_r <= pwdata[eei_pkg::TMR5_ZC_RUN];
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            eei_pkg::ADDR_CTRL1:  prdata_r <= {28'h0, first_int_ctrl_reg_r};
            eei_pkg::ADDR_CTRL2:  prdata_r <= {28'h0, second_int_ctrl_reg_r};
            eei_pkg::ADDR_CTRL3:  prdata_r <= {31'h0, third_int_ctrl_reg_r};
            eei_pkg::ADDR_LCDB:   prdata_r <= {31'h0, lcd_ctrl_reg_b_r};
            eei_pkg::ADDR_ENA:    prdata_r <= {30'h0, enable_bits_reg_a_r};
            eei_pkg::ADDR_TMR2:   prdata_r <= {29'h0, timer2_ctrl_r, 2'b00};
            eei_pkg::ADDR_TMR5:   prdata_r <= {29'h0, fifth_timer_ctrl_r, 2'b00};
            eei_pkg::ADDR_STATUS: prdata_r <= {27'h0, global_irq_enable_r,
                                               zero_cross_flag_r, canceller_flag_r,
                                               ext12_request_flag_r, ext0_request_flag_r};
            default:              prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -----------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [3:0] prev_r;
   logic [3:0] rise;
   logic [3:0] fall;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         prev_r  <= 4'h0;
      end
      else
      begin
         // Ext2 lane carries the OR so the combined edge is seen once
         sync1_r <= {zero_cross_input_pin, ext1_pin | ext2_pin, ext1_pin, ext0_pin};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign rise = sync2_r & ~prev_r;
   assign fall = ~sync2_r & prev_r;

   // Ext0 source is the pin, or the zero-cross input when that detector is on
   logic e0_level;
   logic e0_prev;
   logic e0_edge;
   logic e12_edge;
   logic e12_sel_rise;
   logic e12_src;
   logic e12_prev_src;

   assign e0_level = first_int_ctrl_reg_r[eei_pkg::C1_ZC_EN] ? sync2_r[3] : sync2_r[0];
   assign e0_prev  = first_int_ctrl_reg_r[eei_pkg::C1_ZC_EN] ? prev_r[3] : prev_r[0];

   function automatic logic edge_ok(input logic lvl, input logic prv, input logic [1:0] sel);
      edge_ok = (sel[0] && prv && !lvl) || (sel[1] && !prv && lvl);
   endfunction : edge_ok

   // Edge select: bit 1 falling (plus to minus), bit 2 rising; both for either
   assign e0_edge = edge_ok(e0_level, e0_prev,
                            first_int_ctrl_reg_r[eei_pkg::C1_EDGE_HI:eei_pkg::C1_EDGE_LO]);

   assign e12_sel_rise = second_int_ctrl_reg_r[eei_pkg::C2_EXT1_RISE];
   assign e12_src      = (third_int_ctrl_reg_r && lcd_ctrl_reg_b_r) ? sync2_r[2] : sync2_r[1];
   assign e12_prev_src = (third_int_ctrl_reg_r && lcd_ctrl_reg_b_r) ? prev_r[2] : prev_r[1];
   assign e12_edge = edge_ok(e12_src, e12_prev_src, {e12_sel_rise, !e12_sel_rise});

   // -----------------------------------------------------------------
   // Noise filter: sampled shift register, a stable run accepts the edge
   // -----------------------------------------------------------------
   logic       filt_on;
   logic [6:0] div_cnt_r;
   logic       smp_tick;
   logic [eei_pkg::FILT_BITS-1:0] shreg_r;
   logic       pend_r;
   logic       cancel_set;

   assign filt_on = first_int_ctrl_reg_r[eei_pkg::C1_NF_EN]
                    && second_int_ctrl_reg_r[eei_pkg::C2_SMP_EN];
   assign smp_tick = (div_cnt_r == (second_int_ctrl_reg_r[eei_pkg::C2_DIV_SEL]
                     ? 7'(DIV_SLOW_P - 1) : 7'(DIV_FAST_P - 1)));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_cnt_r <= 7'h00;
      else if (!filt_on || smp_tick)
         div_cnt_r <= 7'h00;
      else
         div_cnt_r <= div_cnt_r + 7'h01;
   end

   // A valid edge arms the filter; another valid edge before the shift register
   // fills restarts it, so the earlier edge is discarded. Free-running sampler
   // phase gives the spread of accepted intervals.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shreg_r <= '0;
         pend_r  <= 1'b0;
      end
      else if (!filt_on)
      begin
         shreg_r <= '0;
         pend_r  <= 1'b0;
      end
      else if (e0_edge)
      begin
         shreg_r <= '0;
         pend_r  <= 1'b1;
      end
      else if (pend_r && smp_tick)
      begin
         shreg_r <= {shreg_r[eei_pkg::FILT_BITS-2:0], 1'b1};
         if (shreg_r[eei_pkg::FILT_BITS-2])
            pend_r <= 1'b0;
      end
   end

   assign cancel_set = pend_r && smp_tick && shreg_r[eei_pkg::FILT_BITS-2] && !e0_edge;

   // -----------------------------------------------------------------
   // Flags
   // -----------------------------------------------------------------
   logic e0_cause;
   logic zc_set;
   logic zc_rose_r;

   // Skip in the same cycle as the canceller set voids that event
   assign e0_cause = filt_on ? (cancel_set && !skip0) : e0_edge;
   assign zc_set   = e0_cause && first_int_ctrl_reg_r[eei_pkg::C1_ZC_EN]
                     && fifth_timer_ctrl_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         canceller_flag_r <= 1'b0;
      else if (cancel_set && !skip0)
         canceller_flag_r <= 1'b1;
      else if (ack0 || skip0 || zc_rose_r)
         canceller_flag_r <= 1'b0;
   end

   // The zero-cross flag rises on the same edge that sets the canceller, and
   // set wins there, so the canceller is cleared one cycle later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         zc_rose_r <= 1'b0;
      else
         zc_rose_r <= zc_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext0_request_flag_r <= 1'b0;
      else if (e0_cause)
         ext0_request_flag_r <= 1'b1;
      else if (ack0 || skip0)
         ext0_request_flag_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext12_request_flag_r <= 1'b0;
      else if (e12_edge)
         ext12_request_flag_r <= 1'b1;
      else if (ack12 || skip12)
         ext12_request_flag_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         zero_cross_flag_r <= 1'b0;
      else if (!fifth_timer_ctrl_r)
         zero_cross_flag_r <= 1'b0;
      else if (zc_set)
         zero_cross_flag_r <= 1'b1;
   end

   // Entry clears global enable; set by command
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         global_irq_enable_r <= 1'b0;
      else if (ack0 || ack12 || (wr_en && hit(paddr, eei_pkg::ADDR_CMD)
               && pwdata[eei_pkg::CMD_GIE_CLR]))
         global_irq_enable_r <= 1'b0;
      else if (wr_en && hit(paddr, eei_pkg::ADDR_CMD) && pwdata[eei_pkg::CMD_GIE_SET])
         global_irq_enable_r <= 1'b1;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign irq_ext0  = ext0_request_flag_r && enable_bits_reg_a_r[eei_pkg::ENA_EXT0]
                      && global_irq_enable_r;
   assign irq_ext12 = ext12_request_flag_r && enable_bits_reg_a_r[eei_pkg::ENA_EXT12]
                      && global_irq_enable_r;
   // Run bit gates too, so a software clear stops the timer on the next cycle
   assign timer2_count_en = timer2_ctrl_r && zero_cross_flag_r
                            && fifth_timer_ctrl_r;
   // Wake level held in first control bit 2 (shared with edge select)
   assign wake_level = first_int_ctrl_reg_r[eei_pkg::C1_EDGE_HI];

endmodule : eei_ctrl

// ==== include/eei_pkg.sv ====
// Package for the external edge interrupt front end: register map, fields, timing
package eei_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL1   = 8'h00;
   localparam logic [7:0] ADDR_CTRL2   = 8'h04;
   localparam logic [7:0] ADDR_CTRL3   = 8'h08;
   localparam logic [7:0] ADDR_LCDB    = 8'h0c;
   localparam logic [7:0] ADDR_ENA     = 8'h10;
   localparam logic [7:0] ADDR_TMR2    = 8'h14;
   localparam logic [7:0] ADDR_TMR5    = 8'h18;
   localparam logic [7:0] ADDR_STATUS  = 8'h1c;
   localparam logic [7:0] ADDR_CMD     = 8'h20;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int C1_NF_EN     = 0;
   localparam int C1_EDGE_LO   = 1;
   localparam int C1_EDGE_HI   = 2;
   localparam int C1_ZC_EN     = 3;
   localparam int C2_DIV_SEL   = 0;
   localparam int C2_SMP_EN    = 1;
   localparam int C2_EXT1_RISE = 2;
   localparam int LCDB_EXT2_EN = 0;
   localparam int ENA_EXT0     = 0;
   localparam int ENA_EXT12    = 1;
   localparam int TMR2_ZC_GATE = 2;
   localparam int TMR5_ZC_RUN  = 2;
   localparam int CMD_SKIP0    = 0;
   localparam int CMD_SKIP12   = 1;
   localparam int CMD_ACK0     = 2;
   localparam int CMD_ACK12    = 3;
   localparam int CMD_GIE_SET  = 4;
   localparam int CMD_GIE_CLR  = 5;

   localparam logic [3:0] CTRL_RST = 4'h0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CYC_PER_MACHINE = 3;
   localparam int DIV_FAST        = 24;
   localparam int DIV_SLOW        = 96;
   localparam int FILT_BITS       = 4;

   typedef struct packed {
      logic ext0;
      logic ext12;
      logic irq;
      logic zc_flag;
      logic t2_run;
   } eei_out_s;

endpackage : eei_pkg

// ==== testbench/eei_ctrl_sva.sv ====
// Port-level checks for the external edge interrupt front end
`timescale 1ns/1ns
module eei_ctrl_sva
#(
   parameter int DIV_FAST_P = eei_pkg::DIV_FAST,
   parameter int DIV_SLOW_P = eei_pkg::DIV_SLOW
)
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ext0_pin,
   input wire logic        ext1_pin,
   input wire logic        ext2_pin,
   input wire logic        zero_cross_input_pin,
   input wire logic        irq_ext0,
   input wire logic        irq_ext12,
   input wire logic        timer2_count_en,
   input wire logic        wake_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wr(a);
      psel && penable && pwrite && paddr == a;
   endsequence
   // Four quiet samples cover the synchroniser and the edge detector
   sequence s_quiet(p);
      $stable(p) [*4];
   endsequence

   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("no error on unmapped access");
   a_err_mapped: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("error on mapped access");
   a_wake_follow: assert property (s_wr(eei_pkg::ADDR_CTRL1) |=> wake_level == $past(pwdata[2]))
      else $error("wake level not from control bit");
   a_gie_off: assert property (s_wr(eei_pkg::ADDR_CMD) ##0 pwdata[5:4] == 2'h2
      |=> !irq_ext0 && !irq_ext12) else $error("irq while globally disabled");
   a_ena_off: assert property (s_wr(eei_pkg::ADDR_ENA) ##0 !pwdata[0] |=> !irq_ext0)
      else $error("ext0 irq while disabled");
   a_skip0_clr: assert property ((s_quiet(ext0_pin) and s_quiet(zero_cross_input_pin))
      ##0 s_wr(eei_pkg::ADDR_CMD) ##0 (pwdata[0] || pwdata[2]) |=> !irq_ext0)
      else $error("ext0 flag not cleared");
   a_ack12_clr: assert property ((s_quiet(ext1_pin) and s_quiet(ext2_pin))
      ##0 s_wr(eei_pkg::ADDR_CMD) ##0 (pwdata[1] || pwdata[3]) |=> !irq_ext12)
      else $error("shared flag not cleared");
   a_sync_ext12: assert property ((s_quiet(ext1_pin) and s_quiet(ext2_pin) and !psel [*4])
      |-> !$rose(irq_ext12)) else $error("shared irq without cause");
   a_zc_stop: assert property (s_wr(eei_pkg::ADDR_TMR5) ##0 !pwdata[2]
      |=> !timer2_count_en [*2]) else $error("zero-cross flag not held clear");
   a_t2_gate: assert property (s_wr(eei_pkg::ADDR_TMR2) ##0 !pwdata[2] |=> !timer2_count_en)
      else $error("timer2 runs while ungated");
endmodule : eei_ctrl_sva

// ==== testbench/eei_src.sv ====
// Signal source model for the four interrupt pins
`timescale 1ns/1ns
module eei_src
(
   input wire logic       pclk,
   input wire logic [3:0] want,
   output logic     [3:0] pins
);
   logic [2:0] hold_r [4];

   initial
   begin
      pins = 4'h0;
      hold_r = '{3'h7, 3'h7, 3'h7, 3'h7};
   end
   // A requested level is delayed until the old one has stood four clocks
   always @(posedge pclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (want[i] != pins[i] && hold_r[i] >= 3'h3)
         begin
            pins[i] <= want[i];
            hold_r[i] <= 3'h0;
         end
         else if (hold_r[i] != 3'h7)
            hold_r[i] <= hold_r[i] + 3'h1;
      end
   end
endmodule : eei_src

// ==== testbench/eei_ctrl_test.sv ====
// Self-checking bench for the external edge interrupt front end
`timescale 1ns/1ns
module eei_ctrl_test;
   localparam int DF = 4;
   localparam int DS = 8;
   localparam logic [7:0] C1 = eei_pkg::ADDR_CTRL1;
   localparam logic [7:0] C2 = eei_pkg::ADDR_CTRL2;
   localparam logic [7:0] ENA = eei_pkg::ADDR_ENA;
   localparam logic [7:0] STS = eei_pkg::ADDR_STATUS;
   localparam logic [7:0] CMD = eei_pkg::ADDR_CMD;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wake;
   logic [3:0]  want = 4'h0;
   logic [3:0]  pins;
   logic [2:0]  outs;
   logic [31:0] rd;
   int          n;
   int          fail_count = 0;
   int          checks_done = 0;

   always #5 pclk = ~pclk;

   eei_src u_src (.pclk(pclk), .want(want), .pins(pins));
   eei_ctrl #(.DIV_FAST_P(DF), .DIV_SLOW_P(DS)) u_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext0_pin(pins[0]), .ext1_pin(pins[1]), .ext2_pin(pins[2]),
      .zero_cross_input_pin(pins[3]), .irq_ext0(outs[0]), .irq_ext12(outs[1]),
      .timer2_count_en(outs[2]), .wake_level(wake)
   );

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   // One transfer; the leading edge keeps two requests from meeting in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         fail_count++;
         finish_test();
      end
      else
      begin
         rd = prdata;
         check("slverr", pslverr, a > 8'h20 || a[1:0] != 2'h0);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check("rdata", rd & m, e);
   endtask : rdc

   task automatic chk_out(input int w, input logic e);
      @(posedge pclk);
      check("output", outs[w], e);
   endtask : chk_out

   // Moves pin p and counts cycles until output w rises, at most lim
   task automatic drive(input int p, input logic v, input int w, input int lim);
      int k;
      @(posedge pclk);
      want[p] <= v;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pins[p] !== v && k < 20);
      n = 0;
      while (outs[w] !== 1'b1 && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
   endtask : drive

   task automatic inr(input int lo, input int hi);
      check("latency", n >= lo && n <= hi, 1'b1);
   endtask : inr

   task automatic t_regs();
      for (int i = 0; i < 8; i++)
         rdc(8'(i * 4), 32'hffffffff, 32'h0);
      wr(C1, 32'hfffffff5);
      rdc(C1, 32'hffffffff, 32'h5);
      check("wake", wake, 1'b1);
      wr(C1, 32'h0);
      rdc(8'h24, 32'hffffffff, 32'h0);
   endtask : t_regs

   task automatic t_ext0();
      wr(C1, 32'h2);
      wr(ENA, 32'h1);
      wr(CMD, 32'h11);
      drive(0, 1'b1, 0, 8);
      inr(8, 8);
      drive(0, 1'b0, 0, 8);
      inr(2, 4);
      rdc(STS, 32'h1f, 32'h11);
      wr(CMD, 32'h20);
      chk_out(0, 1'b0);
      wr(CMD, 32'h10);
      chk_out(0, 1'b1);
      wr(ENA, 32'h0);
      chk_out(0, 1'b0);
      wr(CMD, 32'h01);
      rdc(STS, 32'h1, 32'h0);
      wr(C1, 32'h6);
      wr(ENA, 32'h1);
      drive(0, 1'b1, 0, 8);
      inr(2, 4);
      wr(CMD, 32'h04);
      rdc(STS, 32'h1, 32'h0);
   endtask : t_ext0

   task automatic t_ext12();
      wr(C2, 32'h4);
      wr(ENA, 32'h2);
      wr(CMD, 32'h02);
      wr(CMD, 32'h10);
      drive(1, 1'b1, 1, 8);
      inr(2, 4);
      wr(CMD, 32'h08);
      rdc(STS, 32'h2, 32'h0);
      wr(CMD, 32'h10);
      drive(2, 1'b1, 1, 8);
      inr(8, 8);
      wr(eei_pkg::ADDR_CTRL3, 32'h1);
      wr(eei_pkg::ADDR_LCDB, 32'h1);
      drive(1, 1'b0, 1, 8);
      inr(8, 8);
      drive(2, 1'b0, 1, 8);
      inr(8, 8);
      drive(2, 1'b1, 1, 8);
      inr(2, 4);
      wr(CMD, 32'h08);
      wr(CMD, 32'h10);
      wr(C2, 32'h0);
      drive(2, 1'b0, 1, 8);
      inr(2, 4);
      wr(CMD, 32'h08);
      wr(eei_pkg::ADDR_CTRL3, 32'h0);
   endtask : t_ext12

   task automatic t_filt();
      wr(C1, 32'h7);
      wr(C2, 32'h2);
      wr(ENA, 32'h1);
      wr(CMD, 32'h01);
      wr(CMD, 32'h10);
      drive(0, 1'b0, 0, 60);
      inr(3 * DF, 4 * DF + 6);
      rdc(STS, 32'h4, 32'h4);
      wr(CMD, 32'h01);
      rdc(STS, 32'h5, 32'h0);
      wr(C2, 32'h3);
      // Second edge inside the window must drop the first one
      drive(0, 1'b1, 0, 0);
      repeat (19) @(posedge pclk);
      drive(0, 1'b0, 0, 80);
      inr(3 * DS, 4 * DS + 6);
      wr(CMD, 32'h01);
      wr(C2, 32'h1);
      drive(0, 1'b1, 0, 8);
      inr(2, 4);
      wr(CMD, 32'h01);
   endtask : t_filt

   task automatic t_zc();
      wr(C1, 32'he);
      wr(eei_pkg::ADDR_TMR5, 32'h4);
      wr(eei_pkg::ADDR_TMR2, 32'h4);
      wr(CMD, 32'h01);
      drive(3, 1'b1, 2, 30);
      inr(2, 12);
      rdc(STS, 32'h9, 32'h9);
      wr(eei_pkg::ADDR_TMR5, 32'h0);
      chk_out(2, 1'b0);
      rdc(STS, 32'h8, 32'h0);
   endtask : t_zc

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ext0();
      t_ext12();
      t_filt();
      t_zc();
      finish_test();
   end
endmodule : eei_ctrl_test

bind eei_ctrl eei_ctrl_sva #(.DIV_FAST_P(DIV_FAST_P), .DIV_SLOW_P(DIV_SLOW_P)) u_sva
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .ext2_pin(ext2_pin),
   .zero_cross_input_pin(zero_cross_input_pin), .irq_ext0(irq_ext0),
   .irq_ext12(irq_ext12), .timer2_count_en(timer2_count_en), .wake_level(wake_level)
);
